// ### hdl/ccp_ctrl.sv
// control logic: mic bias, driver short protection, jack detection, bypass and record routing
`timescale 1ns/1ps

// Operation
// - software picks mic bias as 2.0 V, 2.5 V, supply rail or off.
// - shorted driver limits current; status register shows live protection state.
// - with short detection and auto-shutdown both enabled, a shorted driver powers itself down.
// - shut driver stays off, flag held, until software turns it off then on.
// - detect plug insertion, classify headset type, report type in a register.
// - with ac-coupled drivers, mono versus stereo is not told apart.
// - bit 0 closes left positive input1 switch, opens left positive default.
// - bit 2 closes left positive input2 switch, opens left positive default.
// - bit 1 closes left negative input1 switch, opens left negative default.
// - bit 3 closes left negative input2 switch, opens left negative default.
// - bit 4 closes right positive input1 switch, opens right positive default.
// - bit 6 closes right positive input2 switch, opens right positive default.
// - bit 7 closes right negative input2 switch, opens right negative default.
// - record filter enable routes ADC through playback filters only with DACs down.
// - reused filters take coefficients from the playback coefficient locations.
module ccp_ctrl #(
	parameter int NUM_DRV = ccp_pkg::NUM_DRV,
	parameter int DEBOUNCE_CYCLES = ccp_pkg::DEBOUNCE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input ccp_pkg::ccp_bus_req_t bus_req,
	output logic [ccp_pkg::DATA_W-1:0] rdata,
	input wire logic [NUM_DRV-1:0] drv_short_sense,
	input ccp_pkg::ccp_jack_sense_t jack_sense,
	output logic [NUM_DRV-1:0] drv_power_en,
	output logic [NUM_DRV-1:0] drv_current_limit,
	output ccp_pkg::ccp_bias_ctrl_t mic_bias,
	output ccp_pkg::ccp_switch_t line_switches,
	output logic dac_left_power_en,
	output logic dac_right_power_en,
	output logic record_dsp_route_switch,
	output logic [1:0] filt_coef_page
);
	import ccp_pkg::*;

	localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
	localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES);

	typedef struct packed {
		logic [DATA_W-1:0] hs_ctrl;
		logic [DATA_W-1:0] mic_bias;
		logic [DATA_W-1:0] conv_pwr;
		logic [DATA_W-1:0] short_cfg;
		logic [DATA_W-1:0] drv_pwr;
		logic [DATA_W-1:0] rec_route;
		logic [DATA_W-1:0] bypass;
		logic [NUM_DRV-1:0] short_meta;
		logic [NUM_DRV-1:0] short_sync;
		logic [2:0] jack_meta;
		logic [2:0] jack_sync;
		logic [2:0] jack_prev;
		logic [DB_W-1:0] db_cnt;
		logic plug;
		ccp_hs_type_t hs_type;
		logic [NUM_DRV-1:0] short_flag;
		logic [NUM_DRV-1:0] off_seen;
		logic [DATA_W-1:0] rdata;
	} ccp_state_t;

	logic rst_meta_q;
	logic rst_sync_n_q;
	ccp_state_t s_q;
	ccp_state_t s_d;
	logic [NUM_DRV-1:0] drv_on;
	logic [NUM_DRV-1:0] live_prot;
	logic [DATA_W-1:0] short_status;
	logic [DATA_W-1:0] hs_status;
	logic rec_route_on;
	logic det_en;
	logic ac_coupled;
	logic short_det_en;
	logic auto_pd_en;
	logic rec_filt_req;
	ccp_bias_mode_t bias_mode;
	ccp_hs_type_t hs_class;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_q <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	always_comb begin
		// named views of the control fields read below
		det_en = s_q.hs_ctrl[HS_DET_EN];
		ac_coupled = s_q.hs_ctrl[HS_AC_COUPLED];
		short_det_en = s_q.short_cfg[SC_DET_EN];
		auto_pd_en = s_q.short_cfg[SC_AUTO_PD];
		rec_filt_req = s_q.rec_route[RR_FILT_EN];
		bias_mode = ccp_bias_mode_t'(s_q.mic_bias[MB_MODE_LSB +: 2]);
		// a flagged driver stays off until software cycles its power bit
		for (int i = 0; i < NUM_DRV; i++) begin
			drv_on[i] = s_q.drv_pwr[i] & ~s_q.short_flag[i];
			live_prot[i] = s_q.short_sync[i] & s_q.drv_pwr[i];
		end
		short_status = '0;
		short_status[SS_LIVE_LSB +: NUM_DRV] = live_prot;
		short_status[SS_FLAG_LSB +: NUM_DRV] = s_q.short_flag;
		hs_status = s_q.hs_ctrl & HS_RW_MASK;
		hs_status[HS_TYPE_LSB +: 2] = s_q.hs_type;
		hs_status[HS_PLUG] = s_q.plug;
		// the pathway stays closed while either playback converter is powered
		rec_route_on = rec_filt_req & ~s_q.conv_pwr[CP_DAC_L] & ~s_q.conv_pwr[CP_DAC_R];
	end

	// classification of a settled contact pattern
	always_comb begin
		if (!s_q.jack_sync[2]) begin
			hs_class = CCP_HS_NONE;
		end else if (s_q.jack_sync[1]) begin
			hs_class = CCP_HS_HEADSET;
		end else if (s_q.jack_sync[0] && !ac_coupled) begin
			hs_class = CCP_HS_MONO;
		end else begin
			// ac-coupled wiring cannot separate mono from stereo plugs
			hs_class = CCP_HS_STEREO;
		end
	end

	always_comb begin
		s_d = s_q;

		// two-flop synchronisers for the analog comparators and jack contacts
		s_d.short_meta = drv_short_sense;
		s_d.short_sync = s_q.short_meta;
		s_d.jack_meta = {jack_sense.plug, jack_sense.mic, jack_sense.mono};
		s_d.jack_sync = s_q.jack_meta;

		// register writes; read-only locations ignore writes
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				OFS_HEADSET_TYPE: begin
					s_d.hs_ctrl = bus_req.wdata & HS_RW_MASK;
				end
				OFS_MIC_BIAS: begin
					s_d.mic_bias = bus_req.wdata;
				end
				OFS_CONV_PWR: begin
					s_d.conv_pwr = bus_req.wdata;
				end
				OFS_DRV_SHORT_CFG: begin
					s_d.short_cfg = bus_req.wdata;
				end
				OFS_DRV_POWER: begin
					s_d.drv_pwr = bus_req.wdata;
				end
				OFS_REC_ROUTE: begin
					s_d.rec_route = bus_req.wdata;
				end
				OFS_BYPASS_SW: begin
					s_d.bypass = bus_req.wdata;
				end
				default: begin
					s_d.hs_ctrl = s_q.hs_ctrl;
				end
			endcase
		end

		// short flags: an off command arms the clear, the following on command clears
		for (int i = 0; i < NUM_DRV; i++) begin
			if (s_q.short_flag[i] && !s_q.drv_pwr[i]) begin
				s_d.off_seen[i] = 1'b1;
			end
			if (s_q.short_flag[i] && s_q.off_seen[i] && s_q.drv_pwr[i]) begin
				s_d.short_flag[i] = 1'b0;
				s_d.off_seen[i] = 1'b0;
			end
			if (!s_q.short_flag[i]) begin
				s_d.off_seen[i] = 1'b0;
			end
			// a short sensed in the clearing cycle keeps the flag set
			if (live_prot[i] && short_det_en && auto_pd_en) begin
				s_d.short_flag[i] = 1'b1;
				s_d.off_seen[i] = s_q.off_seen[i] & s_q.short_flag[i] & ~s_q.drv_pwr[i];
			end
		end

		// jack detection: contacts must hold still for the debounce time
		s_d.jack_prev = s_q.jack_sync;
		if (!det_en) begin
			s_d.db_cnt = '0;
			s_d.plug = 1'b0;
			s_d.hs_type = CCP_HS_NONE;
		end else if (s_q.jack_sync != s_q.jack_prev) begin
			s_d.db_cnt = '0;
		end else if (s_q.db_cnt != DB_LAST) begin
			s_d.db_cnt = s_q.db_cnt + DB_W'(1);
		end else begin
			s_d.plug = s_q.jack_sync[2];
			s_d.hs_type = hs_class;
		end

		// read data stands only in the cycle after the read strobe
		s_d.rdata = '0;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				OFS_HEADSET_TYPE: begin
					s_d.rdata = hs_status;
				end
				OFS_MIC_BIAS: begin
					s_d.rdata = s_q.mic_bias;
				end
				OFS_CONV_PWR: begin
					s_d.rdata = s_q.conv_pwr;
				end
				OFS_DRV_SHORT_CFG: begin
					s_d.rdata = s_q.short_cfg;
				end
				OFS_DRV_POWER: begin
					s_d.rdata = s_q.drv_pwr;
				end
				OFS_SHORT_STATUS: begin
					s_d.rdata = short_status;
				end
				OFS_REC_ROUTE: begin
					s_d.rdata = s_q.rec_route;
				end
				OFS_BYPASS_SW: begin
					s_d.rdata = s_q.bypass;
				end
				default: begin
					s_d.rdata = '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			s_q.hs_ctrl <= RST_HEADSET_CTRL;
			s_q.mic_bias <= RST_MIC_BIAS;
			s_q.conv_pwr <= RST_CONV_PWR;
			s_q.short_cfg <= RST_DRV_SHORT_CFG;
			s_q.drv_pwr <= RST_DRV_POWER;
			s_q.rec_route <= RST_REC_ROUTE;
			s_q.bypass <= RST_BYPASS_SW;
			s_q.short_meta <= '0;
			s_q.short_sync <= '0;
			s_q.jack_meta <= '0;
			s_q.jack_sync <= '0;
			s_q.jack_prev <= '0;
			s_q.db_cnt <= '0;
			s_q.plug <= 1'b0;
			s_q.hs_type <= CCP_HS_NONE;
			s_q.short_flag <= '0;
			s_q.off_seen <= '0;
			s_q.rdata <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign drv_power_en = drv_on;
	// limiting is always on in hardware; the output mirrors live protection
	assign drv_current_limit = live_prot;

	// bias mode decode
	always_comb begin
		mic_bias = '0;
		unique case (bias_mode)
			CCP_BIAS_OFF: begin
				mic_bias = '0;
			end
			CCP_BIAS_2V0: begin
				mic_bias.power_en = 1'b1;
			end
			CCP_BIAS_2V5: begin
				mic_bias.power_en = 1'b1;
				mic_bias.level_2v5 = 1'b1;
			end
			CCP_BIAS_SUPPLY: begin
				// the supply switch bypasses the bandgap generator, which stays off
				mic_bias.to_analog_supply_rail = 1'b1;
			end
		endcase
	end

	// each bit is a live level; two closures on one pin are not blocked here
	always_comb begin
		line_switches.left_pos_input1_switch = s_q.bypass[BP_L_POS_IN1];
		line_switches.left_pos_input2_switch = s_q.bypass[BP_L_POS_IN2];
		line_switches.left_pos_default_switch = ~(s_q.bypass[BP_L_POS_IN1] | s_q.bypass[BP_L_POS_IN2]);
		line_switches.left_neg_input1_switch = s_q.bypass[BP_L_NEG_IN1];
		line_switches.left_neg_input2_switch = s_q.bypass[BP_L_NEG_IN2];
		line_switches.left_neg_default_switch = ~(s_q.bypass[BP_L_NEG_IN1] | s_q.bypass[BP_L_NEG_IN2]);
		line_switches.right_pos_input1_switch = s_q.bypass[BP_R_POS_IN1];
		line_switches.right_pos_input2_switch = s_q.bypass[BP_R_POS_IN2];
		line_switches.right_pos_default_switch = ~(s_q.bypass[BP_R_POS_IN1] | s_q.bypass[BP_R_POS_IN2]);
		line_switches.right_neg_input1_switch = s_q.bypass[BP_R_NEG_IN1];
		line_switches.right_neg_input2_switch = s_q.bypass[BP_R_NEG_IN2];
		line_switches.right_neg_default_switch = ~(s_q.bypass[BP_R_NEG_IN1] | s_q.bypass[BP_R_NEG_IN2]);
	end

	assign dac_left_power_en = s_q.conv_pwr[CP_DAC_L];
	assign dac_right_power_en = s_q.conv_pwr[CP_DAC_R];
	assign record_dsp_route_switch = rec_route_on;
	// coefficient addressing never moves: record reuse reads the playback bank
	assign filt_coef_page = COEF_PAGE_PLAYBACK;

endmodule

// ### hdl/ccp_pkg.sv
// package: register map, field layout and carriers for the codec path protection control
package ccp_pkg;

	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int NUM_DRV = 4;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_HEADSET_TYPE = 7'h0D;
	localparam logic [ADDR_W-1:0] OFS_MIC_BIAS = 7'h19;
	localparam logic [ADDR_W-1:0] OFS_CONV_PWR = 7'h25;
	localparam logic [ADDR_W-1:0] OFS_DRV_SHORT_CFG = 7'h26;
	localparam logic [ADDR_W-1:0] OFS_DRV_POWER = 7'h33;
	localparam logic [ADDR_W-1:0] OFS_SHORT_STATUS = 7'h5F;
	localparam logic [ADDR_W-1:0] OFS_REC_ROUTE = 7'h6B;
	localparam logic [ADDR_W-1:0] OFS_BYPASS_SW = 7'h6C;

	// reset values
	localparam logic [DATA_W-1:0] RST_HEADSET_CTRL = 8'h00;
	localparam logic [DATA_W-1:0] RST_MIC_BIAS = 8'h00;
	localparam logic [DATA_W-1:0] RST_CONV_PWR = 8'h00;
	localparam logic [DATA_W-1:0] RST_DRV_SHORT_CFG = 8'h00;
	localparam logic [DATA_W-1:0] RST_DRV_POWER = 8'h00;
	localparam logic [DATA_W-1:0] RST_REC_ROUTE = 8'h00;
	localparam logic [DATA_W-1:0] RST_BYPASS_SW = 8'h00;

	// headset_type_status fields
	localparam int HS_DET_EN = 7;
	localparam int HS_TYPE_LSB = 5;
	localparam int HS_AC_COUPLED = 4;
	localparam int HS_PLUG = 0;
	localparam logic [DATA_W-1:0] HS_RW_MASK = 8'h90;
	// mic_bias_select field
	localparam int MB_MODE_LSB = 6;
	// converter_power_ctrl fields
	localparam int CP_DAC_L = 7;
	localparam int CP_DAC_R = 6;
	// driver_short_config fields
	localparam int SC_DET_EN = 2;
	localparam int SC_AUTO_PD = 1;
	// short_circuit_status: live protection in upper nibble, flags in lower
	localparam int SS_LIVE_LSB = 4;
	localparam int SS_FLAG_LSB = 0;
	// record_filter_route field
	localparam int RR_FILT_EN = 3;
	// passive_bypass_switches fields
	localparam int BP_L_POS_IN1 = 0;
	localparam int BP_L_NEG_IN1 = 1;
	localparam int BP_L_POS_IN2 = 2;
	localparam int BP_L_NEG_IN2 = 3;
	localparam int BP_R_POS_IN1 = 4;
	localparam int BP_R_NEG_IN1 = 5;
	localparam int BP_R_POS_IN2 = 6;
	localparam int BP_R_NEG_IN2 = 7;

	// coefficient page shared by playback and reused record filters
	localparam logic [1:0] COEF_PAGE_PLAYBACK = 2'h1;
	localparam int DEBOUNCE_CYCLES = 16;

	typedef enum logic [1:0] {
		CCP_BIAS_OFF = 2'h0,
		CCP_BIAS_2V0 = 2'h1,
		CCP_BIAS_2V5 = 2'h2,
		CCP_BIAS_SUPPLY = 2'h3
	} ccp_bias_mode_t;

	typedef enum logic [1:0] {
		CCP_HS_NONE = 2'h0,
		CCP_HS_STEREO = 2'h1,
		CCP_HS_MONO = 2'h2,
		CCP_HS_HEADSET = 2'h3
	} ccp_hs_type_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ccp_bus_req_t;

	typedef struct packed {
		logic power_en;
		logic level_2v5;
		logic to_analog_supply_rail;
	} ccp_bias_ctrl_t;

	typedef struct packed {
		logic left_pos_default_switch;
		logic left_pos_input1_switch;
		logic left_pos_input2_switch;
		logic left_neg_default_switch;
		logic left_neg_input1_switch;
		logic left_neg_input2_switch;
		logic right_pos_default_switch;
		logic right_pos_input1_switch;
		logic right_pos_input2_switch;
		logic right_neg_default_switch;
		logic right_neg_input1_switch;
		logic right_neg_input2_switch;
	} ccp_switch_t;

	typedef struct packed {
		logic plug;
		logic mic;
		logic mono;
	} ccp_jack_sense_t;

endpackage

// ### verification/ccp_ctrl_sva.sv
// checker: port-level assertions for the codec path protection control
`timescale 1ns/1ps
module ccp_ctrl_sva #(
	parameter int NUM_DRV = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input ccp_pkg::ccp_bus_req_t bus_req,
	input wire logic [ccp_pkg::DATA_W-1:0] rdata,
	input wire logic [NUM_DRV-1:0] drv_short_sense,
	input wire logic [NUM_DRV-1:0] drv_power_en,
	input wire logic [NUM_DRV-1:0] drv_current_limit,
	input ccp_pkg::ccp_bias_ctrl_t mic_bias,
	input ccp_pkg::ccp_switch_t line_switches,
	input wire logic dac_left_power_en,
	input wire logic dac_right_power_en,
	input wire logic record_dsp_route_switch,
	input wire logic [1:0] filt_coef_page
);
	import ccp_pkg::*;
	logic [7:0] bp_bits;
	assign bp_bits = {line_switches.right_neg_input2_switch, line_switches.right_pos_input2_switch,
		line_switches.right_neg_input1_switch, line_switches.right_pos_input1_switch,
		line_switches.left_neg_input2_switch, line_switches.left_pos_input2_switch,
		line_switches.left_neg_input1_switch, line_switches.left_pos_input1_switch};
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence bp_wr_s;
		bus_req.wr && bus_req.addr == OFS_BYPASS_SW;
	endsequence
	sequence mb_wr_s;
		bus_req.wr && bus_req.addr == OFS_MIC_BIAS;
	endsequence
	bypass_map_a: assert property (bp_wr_s |=> bp_bits == $past(bus_req.wdata))
		else $error("bypass switches differ from written value");
	left_defaults_a: assert property ({line_switches.left_pos_default_switch, line_switches.left_neg_default_switch}
		== ~{bp_bits[0] | bp_bits[2], bp_bits[1] | bp_bits[3]}) else $error("left default switch wrong");
	right_defaults_a: assert property ({line_switches.right_pos_default_switch, line_switches.right_neg_default_switch}
		== ~{bp_bits[4] | bp_bits[6], bp_bits[5] | bp_bits[7]}) else $error("right default switch wrong");
	bias_decode_a: assert property (mb_wr_s |=> mic_bias.power_en == (^$past(bus_req.wdata[7:6]))
		&& mic_bias.level_2v5 == ($past(bus_req.wdata[7:6]) == 2'h2)
		&& mic_bias.to_analog_supply_rail == ($past(bus_req.wdata[7:6]) == 2'h3)) else $error("mic bias decode wrong");
	record_gate_a: assert property (record_dsp_route_switch |-> !dac_left_power_en && !dac_right_power_en)
		else $error("record route with a playback converter powered");
	read_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00) else $error("read data outside read slot");
	limit_sense_a: assert property ((drv_current_limit & ~$past(drv_short_sense, 2)) == '0)
		else $error("current limit without a sensed short");
	auto_off_a: assert property ((($past(drv_power_en) & ~drv_power_en) != '0) && !$past(bus_req.wr)
		|-> ($past(drv_power_en) & ~drv_power_en & ~$past(drv_current_limit)) == '0) else $error("driver dropped unasked");
	relight_sw_a: assert property (((drv_power_en & ~$past(drv_power_en)) != '0)
		|-> $past(bus_req.wr) || $past(bus_req.wr, 2)) else $error("driver came back without a write");
	coef_page_a: assert property (filt_coef_page == COEF_PAGE_PLAYBACK) else $error("coefficient page wrong");
endmodule

// ### verification/ccp_load_model.sv
// far-side model: loads on the high-power drivers and a jack with a plug
`timescale 1ns/1ps
module ccp_load_model (
	input wire logic [3:0] drv_power_en,
	input wire logic [3:0] shorted,
	input wire logic [2:0] jack_set,
	output logic [3:0] drv_short_sense,
	output ccp_pkg::ccp_jack_sense_t jack_sense
);
	import ccp_pkg::*;
	// a short only draws current while its driver is powered
	assign drv_short_sense = shorted & drv_power_en;
	// contacts read open with no plug in, whatever the ring wiring
	assign jack_sense = jack_set[2] ? ccp_jack_sense_t'(jack_set) : '0;
endmodule

// ### verification/tb_ccp_ctrl.sv
// testbench: registers, protection, jack and routing of the codec path protection control
`timescale 1ns/1ps
module tb_ccp_ctrl;
	import ccp_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	ccp_bus_req_t req = '0;
	logic [7:0] rdata;
	logic [3:0] sense, pwr, lim;
	logic [3:0] shorted = '0;
	logic [2:0] jack_set = '0;
	ccp_jack_sense_t jack;
	ccp_bias_ctrl_t bias;
	ccp_switch_t sw;
	logic dac_l, dac_r, route;
	logic [1:0] page;
	int errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int m[128];
	logic [7:0] lfsr = 8'h33;
	logic [2:0] js[5] = '{3'b110, 3'b101, 3'b100, 3'b101, 3'b000};
	logic [7:0] jx[5] = '{8'h61, 8'h41, 8'h21, 8'h21, 8'h00};
	ccp_ctrl #(.DEBOUNCE_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .bus_req(req), .rdata(rdata),
		.drv_short_sense(sense), .jack_sense(jack), .drv_power_en(pwr), .drv_current_limit(lim),
		.mic_bias(bias), .line_switches(sw), .dac_left_power_en(dac_l), .dac_right_power_en(dac_r),
		.record_dsp_route_switch(route), .filt_coef_page(page));
	ccp_load_model ld_u (.drv_power_en(pwr), .shorted(shorted), .jack_set(jack_set),
		.drv_short_sense(sense), .jack_sense(jack));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			conclude();
		end
	end
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [11:0] swx(input logic [7:0] v);
		return {~(v[0] | v[2]), v[0], v[2], ~(v[1] | v[3]), v[1], v[3],
			~(v[4] | v[6]), v[4], v[6], ~(v[5] | v[7]), v[5], v[7]};
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		if (a == OFS_HEADSET_TYPE) m[a] = int'(d & HS_RW_MASK);
		if (a inside {OFS_MIC_BIAS, OFS_CONV_PWR, OFS_DRV_SHORT_CFG, OFS_DRV_POWER, OFS_REC_ROUTE, OFS_BYPASS_SW}) m[a] = d;
	endtask
	task automatic chk_rd(input logic [6:0] a, input logic [7:0] extra);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		#1;
		cmp(16'(rdata), 16'(8'(m[a]) | extra));
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] v;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		// every place reads zero after reset, unmapped ones included
		for (int a = 0; a < 128; a++) chk_rd(7'(a), 8'h00);
		wr(7'h7F, 8'hA5);
		chk_rd(7'h7F, 8'h00);
		cmp(16'(sw), 16'(swx(8'h00)));
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			v = (i < 8) ? 8'h01 << i : lfsr;
			lfsr = nxt(lfsr);
			v = v & ~{v[5:4], 2'b00, v[1:0], 2'b00};
			wr(OFS_BYPASS_SW, v);
			tick(1);
			cmp(16'(sw), 16'(swx(v)));
			chk_rd(OFS_BYPASS_SW, 8'h00);
		end
		$display("test bypass done");
		for (int k = 0; k < 4; k++) begin
			wr(OFS_MIC_BIAS, 8'(k << 6));
			tick(1);
			cmp(16'({bias.power_en, bias.to_analog_supply_rail}), 16'({k == 1 || k == 2, k == 3}));
			if (k == 1 || k == 2) cmp(16'(bias.level_2v5), 16'(k == 2));
			chk_rd(OFS_MIC_BIAS, 8'h00);
		end
		$display("test bias done");
		wr(OFS_CONV_PWR, 8'hC0);
		wr(OFS_REC_ROUTE, 8'h08);
		tick(1);
		cmp(16'({dac_l, dac_r, route}), 16'h0006);
		wr(OFS_CONV_PWR, 8'h40);
		tick(1);
		cmp(16'({dac_r, route}), 16'h0002);
		wr(OFS_CONV_PWR, 8'h00);
		tick(1);
		cmp(16'({dac_l, dac_r, route, page}), 16'h0005);
		chk_rd(OFS_REC_ROUTE, 8'h00);
		$display("test record done");
		wr(OFS_DRV_POWER, 8'h0F);
		@(posedge clk);
		shorted <= 4'h1;
		tick(4);
		cmp(16'({lim, pwr}), 16'h001F);
		chk_rd(OFS_SHORT_STATUS, 8'h10);
		// driver 0's short must drain before auto power-down is armed, or it would be flagged too
		@(posedge clk);
		shorted <= 4'h0;
		tick(2);
		cmp(16'(lim), 16'h0000);
		wr(OFS_DRV_SHORT_CFG, 8'h06);
		@(posedge clk);
		shorted <= 4'h2;
		tick(6);
		cmp(16'(pwr), 16'h000D);
		chk_rd(OFS_SHORT_STATUS, 8'h02);
		@(posedge clk);
		shorted <= 4'h0;
		wr(OFS_DRV_POWER, 8'h0F);
		tick(4);
		cmp(16'(pwr), 16'h000D);
		wr(OFS_DRV_POWER, 8'h0D);
		wr(OFS_DRV_POWER, 8'h0F);
		tick(3);
		cmp(16'(pwr), 16'h000F);
		chk_rd(OFS_SHORT_STATUS, 8'h00);
		$display("test short done");
		wr(OFS_HEADSET_TYPE, 8'h80);
		for (int j = 0; j < 5; j++) begin
			if (j == 3) wr(OFS_HEADSET_TYPE, 8'h90);
			@(posedge clk);
			jack_set <= js[j];
			tick(20);
			chk_rd(OFS_HEADSET_TYPE, jx[j]);
		end
		$display("test jack done");
		conclude();
	end
endmodule
bind ccp_ctrl ccp_ctrl_sva #(.NUM_DRV(NUM_DRV)) chk_u (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
	.drv_short_sense(drv_short_sense), .drv_power_en(drv_power_en), .drv_current_limit(drv_current_limit),
	.mic_bias(mic_bias), .line_switches(line_switches), .dac_left_power_en(dac_left_power_en),
	.dac_right_power_en(dac_right_power_en), .record_dsp_route_switch(record_dsp_route_switch),
	.filt_coef_page(filt_coef_page));
